/* File: design/lsp_path_core.sv */
// path routing and transmit clock selection for a two-channel link simulator
// assumes rx and clock pins are asynchronous to clk and far slower than it;
// delay/error generators sit outside and talk valid/ready on clk
//
// Summary of operation
// - at most one installed interface active at once (none before the first pick)
// - first activation of an interface loads type default data rate
// - config saved on leave, restored on return
// - tx clock source chosen per interface
// - loop timing sends on recovered receive clock
// - synthesizer 100 Hz to 52 MHz, 1 Hz
// - rate picks synthesizer or oscillator, HSSI user
// - external reference from rear input or terminal timing
// - internal rate may carry deliberate frequency offset
// - HSSI gapped or continuous clock, int/ext
// - async only on separate clock/data interfaces
// - normal path crosses through opposite channel generators
// - bypass crosses directly, skipping the generators
// - activity lamps dark while bypass selected
// - outward loopback returns each side directly
// - inward loopback returns through own-side generators
// - path takes effect on confirm, readable back
`timescale 1ns/10ps
module lsp_path_core #(
	parameter int LED_HOLD   = lsp_pkg::LED_HOLD_CYC,
	parameter int FIFO_DEPTH = lsp_pkg::FIFO_DEPTH
) (
	input wire logic                      clk,
	input wire logic                      nrst,
	input wire logic [4:0]                if_installed,
	input wire logic [19:0]               if_types,
	input wire logic [2:0]                if_sel,
	input wire logic                      if_sel_stb,
	output logic [4:0]                    if_active,
	output logic                          if_busy,
	input wire lsp_pkg::lsp_cfg_s         cfg_wdata,
	input wire logic                      cfg_wr,
	output lsp_pkg::lsp_cfg_s             cfg_cur,
	input wire logic [1:0]                path_sel,
	input wire logic                      path_stb,
	output logic [1:0]                    path_cur,
	input wire logic                      e_rx_data,
	input wire logic                      e_rx_clk,
	input wire logic                      w_rx_data,
	input wire logic                      w_rx_clk,
	input wire logic                      synth_clk,
	input wire logic                      osc_clk,
	input wire logic                      ext_clk,
	input wire logic                      tt_clk,
	output logic [1:0]                    tx_data,
	output logic [1:0]                    tx_clk,
	output logic [lsp_pkg::RATE_W-1:0]    synth_freq,
	output logic                          synth_en,
	output logic [1:0]                    gen_in_data,
	output logic [1:0]                    gen_in_valid,
	input wire logic [1:0]                gen_out_data,
	input wire logic [1:0]                gen_out_valid,
	output logic [1:0]                    gen_out_ready,
	output logic [3:0]                    act_led
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic is_serial(lsp_pkg::lsp_type_e t);
		is_serial = (t == lsp_pkg::LSP_V35) || (t == lsp_pkg::LSP_RS449)
			|| (t == lsp_pkg::LSP_RS232);
	endfunction : is_serial

	function automatic logic [lsp_pkg::RATE_W-1:0] def_rate(lsp_pkg::lsp_type_e t);
		case (t)
			lsp_pkg::LSP_OC3_MM: def_rate = lsp_pkg::RATE_OC3;
			lsp_pkg::LSP_OC3_SM: def_rate = lsp_pkg::RATE_OC3;
			lsp_pkg::LSP_STS3:   def_rate = lsp_pkg::RATE_OC3;
			lsp_pkg::LSP_STS1:   def_rate = lsp_pkg::RATE_STS1;
			lsp_pkg::LSP_DS3:    def_rate = lsp_pkg::RATE_DS3;
			lsp_pkg::LSP_DS1:    def_rate = lsp_pkg::RATE_DS1;
			lsp_pkg::LSP_E3:     def_rate = lsp_pkg::RATE_E3;
			lsp_pkg::LSP_E1:     def_rate = lsp_pkg::RATE_E1;
			lsp_pkg::LSP_HSSI:   def_rate = lsp_pkg::RATE_HSSI;
			default:             def_rate = lsp_pkg::RATE_SER;
		endcase
	endfunction : def_rate

	// drops options the active interface cannot do
	function automatic lsp_pkg::lsp_cfg_s legal_cfg(lsp_pkg::lsp_cfg_s c,
			lsp_pkg::lsp_type_e t);
		legal_cfg = c;
		legal_cfg.async_m = c.async_m && is_serial(t);
		legal_cfg.gapped = c.gapped && (t == lsp_pkg::LSP_HSSI);
		legal_cfg.hssi_osc = c.hssi_osc && (t == lsp_pkg::LSP_HSSI);
		legal_cfg.ext_tt = c.ext_tt && is_serial(t);
	endfunction : legal_cfg

	// receive port feeding transmit port t: crossing paths take the far side
	function automatic logic feed_port(lsp_pkg::lsp_path_e p, logic t);
		feed_port = (p == lsp_pkg::LSP_NORMAL || p == lsp_pkg::LSP_BYPASS) ? ~t : t;
	endfunction : feed_port

	function automatic logic [2:0] clk_pin(lsp_pkg::lsp_path_e p, lsp_pkg::lsp_cfg_s c,
			logic osc, logic t);
		logic f;
		f = feed_port(p, t);
		if (p == lsp_pkg::LSP_BYPASS || p == lsp_pkg::LSP_OUT_LB
				|| c.tsrc == lsp_pkg::LSP_TS_REC) begin
			clk_pin = f ? 3'(lsp_pkg::PIN_W_RXC) : 3'(lsp_pkg::PIN_E_RXC);
		end else if (c.tsrc == lsp_pkg::LSP_TS_EXT) begin
			clk_pin = c.ext_tt ? 3'(lsp_pkg::PIN_TT) : 3'(lsp_pkg::PIN_EXT);
		end else begin
			clk_pin = osc ? 3'(lsp_pkg::PIN_OSC) : 3'(lsp_pkg::PIN_SYN);
		end
	endfunction : clk_pin

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [lsp_pkg::NUM_PINS-1:0] pin_raw;
	logic [lsp_pkg::NUM_PINS-1:0] pin_s1_r;
	logic [lsp_pkg::NUM_PINS-1:0] pin_s2_r;
	logic [lsp_pkg::NUM_PINS-1:0] pin_s3_r;

	assign pin_raw = {tt_clk, ext_clk, osc_clk, synth_clk,
		w_rx_clk, w_rx_data, e_rx_clk, e_rx_data};

	// third stage only feeds edge detection, never the first stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	// ****************************************
	// interface activation
	// ****************************************
	typedef enum logic [1:0] {SEL_IDLE, SEL_SAVE, SEL_LOAD} lsp_sel_e;

	lsp_sel_e                     sel_st_r;
	logic [2:0]                   act_idx_r;
	logic [2:0]                   new_idx_r;
	logic                         act_vld_r;
	logic [4:0]                   saved_r;
	logic [4:0]                   active_r;
	lsp_pkg::lsp_cfg_s            cur_cfg_r;
	lsp_pkg::lsp_cfg_s            dflt_cfg;
	logic [lsp_pkg::CFG_W-1:0]    mem_rdata;
	logic                         mem_we;
	lsp_pkg::lsp_type_e           act_type;
	logic                         sel_ok;

	assign act_type = lsp_pkg::lsp_type_e'(if_types[act_idx_r*lsp_pkg::TYPE_W +: 4]);
	assign sel_ok = if_sel_stb && (sel_st_r == SEL_IDLE) && (if_sel < 3'(lsp_pkg::NUM_IF))
		&& if_installed[if_sel] && !(act_vld_r && (if_sel == act_idx_r));
	assign mem_we = (sel_st_r == SEL_SAVE) && act_vld_r;

	always_comb begin
		dflt_cfg = '0;
		dflt_cfg.rate = def_rate(act_type);
		dflt_cfg.tsrc = lsp_pkg::LSP_TS_INT;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sel_st_r <= SEL_IDLE;
			new_idx_r <= '0;
		end else begin
			case (sel_st_r)
				SEL_IDLE: begin
					if (sel_ok) begin
						new_idx_r <= if_sel;
						sel_st_r <= SEL_SAVE;
					end
				end
				SEL_SAVE: sel_st_r <= SEL_LOAD;
				SEL_LOAD: sel_st_r <= SEL_IDLE;
				default:  sel_st_r <= SEL_IDLE;
			endcase
		end
	end

	// old interface drops in the same edge the new one rises
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			act_idx_r <= '0;
			act_vld_r <= 1'b0;
			active_r <= '0;
			saved_r <= '0;
		end else if (sel_st_r == SEL_SAVE) begin
			act_idx_r <= new_idx_r;
			act_vld_r <= 1'b1;
			active_r <= 5'h01 << new_idx_r;
			if (act_vld_r) begin
				saved_r[act_idx_r] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cur_cfg_r <= '0;
		end else if (sel_st_r == SEL_LOAD) begin
			cur_cfg_r <= saved_r[act_idx_r] ? lsp_pkg::lsp_cfg_s'(mem_rdata) : dflt_cfg;
		end else if (sel_st_r == SEL_IDLE && cfg_wr && act_vld_r) begin
			cur_cfg_r <= legal_cfg(cfg_wdata, act_type);
		end
	end

	lsp_cfg_mem #(
		.W     (lsp_pkg::CFG_W),
		.DEPTH (lsp_pkg::NUM_IF),
		.AW    (lsp_pkg::IDX_W)
	) u_cfg_mem (
		.clk   (clk),
		.nrst  (nrst),
		.we    (mem_we),
		.waddr (act_idx_r),
		.wdata (cur_cfg_r),
		.raddr (new_idx_r),
		.rdata (mem_rdata)
	);

	assign if_active = active_r;
	assign if_busy = (sel_st_r != SEL_IDLE);
	assign cfg_cur = cur_cfg_r;

	// ****************************************
	// internal timing: synthesizer or oscillator
	// ****************************************
	localparam logic signed [29:0] SMIN = 30'(lsp_pkg::SYN_MIN_HZ);
	localparam logic signed [29:0] SMAX = 30'(lsp_pkg::SYN_MAX_HZ);

	logic                    use_osc;
	logic signed [29:0]      syn_sum;
	logic [lsp_pkg::RATE_W-1:0] syn_freq_r;
	logic                    syn_en_r;

	// on non-serial, non-HSSI cards, rates above the synthesizer's reach or at the card's own rate use the oscillator
	assign use_osc = (act_type == lsp_pkg::LSP_HSSI) ? cur_cfg_r.hssi_osc
		: (!is_serial(act_type) && (cur_cfg_r.rate == def_rate(act_type)
		|| cur_cfg_r.rate > lsp_pkg::SYN_MAX_HZ));
	assign syn_sum = $signed({2'b00, cur_cfg_r.rate}) + 30'(cur_cfg_r.ofs);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			syn_freq_r <= lsp_pkg::SYN_MIN_HZ;
			syn_en_r <= 1'b0;
		end else begin
			if (syn_sum < SMIN) begin
				syn_freq_r <= lsp_pkg::SYN_MIN_HZ;
			end else if (syn_sum > SMAX) begin
				syn_freq_r <= lsp_pkg::SYN_MAX_HZ;
			end else begin
				syn_freq_r <= syn_sum[lsp_pkg::RATE_W-1:0];
			end
			syn_en_r <= act_vld_r && (cur_cfg_r.tsrc == lsp_pkg::LSP_TS_INT) && !use_osc;
		end
	end

	assign synth_freq = syn_freq_r;
	assign synth_en = syn_en_r;

	// ****************************************
	// data path select
	// ****************************************
	lsp_pkg::lsp_path_e path_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			path_r <= lsp_pkg::LSP_NORMAL;
		end else if (path_stb) begin
			path_r <= lsp_pkg::lsp_path_e'(path_sel);
		end
	end

	assign path_cur = path_r;

	// ****************************************
	// per transmit port: generator feed, fifo, clocking
	// ****************************************
	for (genvar g = 0; g < 2; g++) begin : g_tx
		logic       fp;
		logic [2:0] ci;
		logic       direct;
		logic       gap_on;
		logic       clk_fall;
		logic       src_rise;
		logic       in_dat_r;
		logic       in_vld_r;
		logic       dat_r;
		logic       clk_r;

		lsp_strm_if #(.W(1)) wr_if ();
		lsp_strm_if #(.W(1)) rd_if ();

		// both ports read the one path register, so routes never disagree
		assign fp = feed_port(path_r, 1'(g));
		assign ci = clk_pin(path_r, cur_cfg_r, use_osc, 1'(g));
		// unclocked async data cannot go through bit-clocked generators
		assign direct = (path_r == lsp_pkg::LSP_BYPASS) || (path_r == lsp_pkg::LSP_OUT_LB)
			|| cur_cfg_r.async_m;
		assign gap_on = cur_cfg_r.gapped && (cur_cfg_r.tsrc != lsp_pkg::LSP_TS_REC);
		assign clk_fall = !pin_s2_r[ci] && pin_s3_r[ci];
		assign src_rise = pin_s2_r[2*fp+1] && !pin_s3_r[2*fp+1];

		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				in_dat_r <= 1'b0;
				in_vld_r <= 1'b0;
			end else begin
				in_dat_r <= pin_s2_r[2*fp];
				in_vld_r <= !direct && src_rise;
			end
		end

		assign wr_if.valid = gen_out_valid[g];
		assign wr_if.data = gen_out_data[g];
		assign gen_out_ready[g] = wr_if.ready;
		assign rd_if.ready = !direct && clk_fall;

		lsp_fifo #(
			.W     (1),
			.DEPTH (FIFO_DEPTH)
		) u_fifo (
			.clk  (clk),
			.nrst (nrst),
			.wr   (wr_if),
			.rd   (rd_if)
		);

		// data changes on the falling edge so the far end samples on the rising one
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				dat_r <= 1'b0;
				clk_r <= 1'b0;
			end else if (direct) begin
				dat_r <= pin_s2_r[2*fp];
				clk_r <= !cur_cfg_r.async_m && pin_s2_r[2*fp+1];
			end else begin
				if (rd_if.ready && rd_if.valid) begin
					dat_r <= rd_if.data;
				end
				clk_r <= pin_s2_r[ci] && (!gap_on || rd_if.valid);
			end
		end

		assign gen_in_data[g] = in_dat_r;
		assign gen_in_valid[g] = in_vld_r;
		assign tx_data[g] = dat_r;
		assign tx_clk[g] = clk_r;
	end

	// ****************************************
	// activity lamps
	// ****************************************
	localparam int LW = $clog2(LED_HOLD + 1);

	logic [1:0]   tx_prev_r;
	logic [3:0]   act_evt;
	logic [LW-1:0] led_cnt_r [4];

	// order: east rx, east tx, west rx, west tx
	assign act_evt = {tx_data[1] ^ tx_prev_r[1],
		pin_s2_r[lsp_pkg::PIN_W_RXD] ^ pin_s3_r[lsp_pkg::PIN_W_RXD],
		tx_data[0] ^ tx_prev_r[0],
		pin_s2_r[lsp_pkg::PIN_E_RXD] ^ pin_s3_r[lsp_pkg::PIN_E_RXD]};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_prev_r <= '0;
			for (int i = 0; i < 4; i++) begin
				led_cnt_r[i] <= '0;
			end
		end else begin
			tx_prev_r <= tx_data;
			for (int i = 0; i < 4; i++) begin
				if (act_evt[i]) begin
					led_cnt_r[i] <= LW'(LED_HOLD);
				end else if (led_cnt_r[i] != '0) begin
					led_cnt_r[i] <= led_cnt_r[i] - 1'b1;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			act_led[i] = (led_cnt_r[i] != '0) && (path_r != lsp_pkg::LSP_BYPASS);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_switch;
		sel_ok ##1 (sel_st_r == SEL_SAVE) ##1 (sel_st_r == SEL_LOAD);
	endsequence

	a_one_active: assert property ($onehot0(if_active))
		else $error("more than one interface active");
	a_sel_switch: assert property (sel_ok |-> ##2 if_active == (5'h01 << $past(if_sel, 2)))
		else $error("selected interface not the only active one");
	a_default_rate: assert property ((s_switch ##0 !saved_r[act_idx_r])
		|=> cfg_cur.rate == def_rate(act_type))
		else $error("fresh interface lacks its type rate");
	a_restore_cfg: assert property ((s_switch ##0 saved_r[act_idx_r])
		|=> cfg_cur == $past(mem_rdata))
		else $error("saved configuration not restored");
	a_synth_range: assert property (synth_en |-> (synth_freq >= lsp_pkg::SYN_MIN_HZ)
		&& (synth_freq <= lsp_pkg::SYN_MAX_HZ))
		else $error("synthesizer outside range");
	a_int_osc: assert property ((cfg_cur.tsrc == lsp_pkg::LSP_TS_INT) && !is_serial(act_type)
		&& (act_type != lsp_pkg::LSP_HSSI) && (cfg_cur.rate == def_rate(act_type))
		|=> !synth_en)
		else $error("nominal rate not on oscillator");
	a_loop_clock: assert property (((path_r == lsp_pkg::LSP_NORMAL)
		&& (cfg_cur.tsrc == lsp_pkg::LSP_TS_REC) && !cfg_cur.async_m)[*2]
		|-> tx_clk[0] == $past(pin_s2_r[lsp_pkg::PIN_W_RXC]))
		else $error("east tx not on west recovered clock");
	a_normal_feed: assert property ((path_r == lsp_pkg::LSP_NORMAL)[*2] ##0 gen_in_valid[0]
		|-> gen_in_data[0] == $past(pin_s2_r[lsp_pkg::PIN_W_RXD]))
		else $error("east generator not fed from west");
	a_inward_feed: assert property ((path_r == lsp_pkg::LSP_IN_LB)[*2] ##0 gen_in_valid[0]
		|-> gen_in_data[0] == $past(pin_s2_r[lsp_pkg::PIN_E_RXD]))
		else $error("east generator not fed from east");
	a_bypass_route: assert property ((path_r == lsp_pkg::LSP_BYPASS)[*2] |-> tx_data
		== {$past(pin_s2_r[lsp_pkg::PIN_E_RXD]), $past(pin_s2_r[lsp_pkg::PIN_W_RXD])})
		else $error("bypass route wrong");
	a_outward_route: assert property ((path_r == lsp_pkg::LSP_OUT_LB)[*2] |-> tx_data
		== {$past(pin_s2_r[lsp_pkg::PIN_W_RXD]), $past(pin_s2_r[lsp_pkg::PIN_E_RXD])})
		else $error("outward loopback route wrong");
	a_bypass_dark: assert property ((path_cur == lsp_pkg::LSP_BYPASS) |-> act_led == 4'h0)
		else $error("lamp lit in bypass");
	a_path_apply: assert property (path_stb |=> path_cur == $past(path_sel))
		else $error("path not applied on confirm");
	// while switching, cfg_cur still belongs to the old slot for one cycle
	a_async_legal: assert property (!if_busy && cfg_cur.async_m |-> is_serial(act_type))
		else $error("async on combined clock/data interface");
	a_gapped_hssi: assert property (!if_busy && cfg_cur.gapped
		|-> act_type == lsp_pkg::LSP_HSSI)
		else $error("gapped clock off HSSI");
endmodule : lsp_path_core

/* File: design/lsp_pkg.sv */
// constants and types shared by the link path and transmit timing core
// assumes one system clock at CLK_HZ; all rates are in Hz
package lsp_pkg;
	// ****************************************
	// sizes and timing
	// ****************************************
	localparam int NUM_IF       = 5;
	localparam int IDX_W        = 3;
	localparam int TYPE_W       = 4;
	localparam int RATE_W       = 28;
	localparam int OFS_W        = 16;
	localparam int CLK_HZ       = 40_000_000;
	localparam int LED_HOLD_US  = 20;
	localparam int LED_HOLD_CYC = LED_HOLD_US * (CLK_HZ / 1_000_000);
	localparam int FIFO_DEPTH   = 8;

	// ****************************************
	// rates
	// ****************************************
	localparam logic [RATE_W-1:0] SYN_MIN_HZ = 28'h0000064;
	localparam logic [RATE_W-1:0] SYN_MAX_HZ = 28'h3197500;
	localparam logic [RATE_W-1:0] RATE_OC3   = 28'h9450c00;
	localparam logic [RATE_W-1:0] RATE_STS1  = 28'h3170400;
	localparam logic [RATE_W-1:0] RATE_DS3   = 28'h2aa9e00;
	localparam logic [RATE_W-1:0] RATE_E3    = 28'h20c6a00;
	localparam logic [RATE_W-1:0] RATE_DS1   = 28'h0178f40;
	localparam logic [RATE_W-1:0] RATE_E1    = 28'h01f4000;
	localparam logic [RATE_W-1:0] RATE_HSSI  = 28'h2aea540;
	localparam logic [RATE_W-1:0] RATE_SER   = 28'h000fa00;

	// ****************************************
	// synchronised pin positions, port index 0 east, 1 west
	// ****************************************
	localparam int PIN_E_RXD = 0;
	localparam int PIN_E_RXC = 1;
	localparam int PIN_W_RXD = 2;
	localparam int PIN_W_RXC = 3;
	localparam int PIN_SYN   = 4;
	localparam int PIN_OSC   = 5;
	localparam int PIN_EXT   = 6;
	localparam int PIN_TT    = 7;
	localparam int NUM_PINS  = 8;

	typedef enum logic [1:0] {LSP_NORMAL, LSP_BYPASS, LSP_OUT_LB, LSP_IN_LB} lsp_path_e;
	typedef enum logic [1:0] {LSP_TS_REC, LSP_TS_INT, LSP_TS_EXT} lsp_tsrc_e;
	typedef enum logic [TYPE_W-1:0] {
		LSP_OC3_MM, LSP_OC3_SM, LSP_STS3, LSP_STS1, LSP_DS3, LSP_DS1,
		LSP_E3, LSP_E1, LSP_HSSI, LSP_V35, LSP_RS449, LSP_RS232
	} lsp_type_e;

	typedef struct packed {
		logic [RATE_W-1:0]       rate;
		logic signed [OFS_W-1:0] ofs;
		lsp_tsrc_e               tsrc;
		logic                    ext_tt;
		logic                    hssi_osc;
		logic                    gapped;
		logic                    async_m;
	} lsp_cfg_s;

	localparam int CFG_W = $bits(lsp_cfg_s);
endpackage : lsp_pkg

/* File: design/lsp_strm_if.sv */
// valid/ready stream between the core and its fifos
// assumes both ends on the same clock
`timescale 1ns/10ps
interface lsp_strm_if #(
	parameter int W = 1
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : lsp_strm_if

/* File: design/lsp_fifo.sv */
// small synchronous fifo between a generator return and a transmit port
// assumes DEPTH is a power of two and both sides run on clk
`timescale 1ns/10ps
module lsp_fifo #(
	parameter int W     = 1,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	lsp_strm_if.snk  wr,
	lsp_strm_if.src  rd
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_r [DEPTH];
	logic [AW:0]  wp_r;
	logic [AW:0]  rp_r;
	logic         full;
	logic         empty;
	logic         push;
	logic         pop;

	// extra pointer bit tells full from empty
	assign full     = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign empty    = (wp_r == rp_r);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = mem_r[rp_r[AW-1:0]];
	assign push     = wr.valid && !full;
	assign pop      = rd.ready && !empty;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r[AW-1:0]] <= wr.data;
		end
	end
endmodule : lsp_fifo

/* File: design/lsp_cfg_mem.sv */
// per-interface saved configuration store, registered read
// assumes one write and one read per cycle at different addresses
`timescale 1ns/10ps
module lsp_cfg_mem #(
	parameter int W     = 32,
	parameter int DEPTH = 5,
	parameter int AW    = 3
) (
	input wire logic          clk,
	input wire logic          nrst,
	input wire logic          we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0]  wdata,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0]      rdata
);
	logic [W-1:0] mem_r [DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem_r[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= '0;
		end else begin
			rdata <= mem_r[raddr];
		end
	end
endmodule : lsp_cfg_mem

/* File: tb/lsp_eut.sv */
// far-side equipment model: sends a bit pattern with its own line clock
// assumes 200 ns link clock, still while run is low; loop-timed on txc while lt is high
`timescale 1ns/10ps
module lsp_eut #(
	parameter logic [7:0] PAT = 8'ha5
) (
	input wire logic lt,
	input wire logic txc,
	input wire logic run,
	output logic     rxd,
	output logic     rxc
);
	int i;
	initial begin
		rxd = 1'b0;
		rxc = 1'b0;
		i = 0;
		forever begin
			wait (run);
			rxd = PAT[i%8];
			if (lt) begin
				@(posedge txc) rxc = 1'b1;
				@(negedge txc) rxc = 1'b0;
			end else begin
				#100 rxc = 1'b1;
				#100 rxc = 1'b0;
			end
			i++;
		end
	end
endmodule : lsp_eut

/* File: tb/link_sim_path_and_timing_select_tb.sv */
// self-checking bench for the path and transmit timing core
// assumes lsp_eut on both sides; generator outputs looped back to returns
`timescale 1ns/10ps
module link_sim_path_and_timing_select_tb;
	logic clk = 1'b0, nrst = 1'b0, if_sel_stb = 1'b0, cfg_wr = 1'b0, path_stb = 1'b0;
	logic [4:0] if_installed = 5'h03;
	logic [19:0] if_types = 20'h00084;
	logic [2:0] if_sel = 3'h0;
	logic [1:0] path_sel = 2'h0;
	lsp_pkg::lsp_cfg_s cfg_wdata = '0;
	lsp_pkg::lsp_cfg_s cfg_cur;
	logic run = 1'b0, synth_clk = 1'b0, e_smp, w_smp, if_busy, synth_en;
	logic lt = 1'b0, osc_clk = 1'b0, ext_clk = 1'b1, tt_clk = 1'b0;
	logic e_rx_data, e_rx_clk, w_rx_data, w_rx_clk;
	logic [4:0] if_active;
	logic [1:0] path_cur, tx_data, tx_clk, gen_in_data, gen_in_valid, gen_out_ready;
	logic [27:0] synth_freq;
	logic [3:0] act_led;
	int n_mismatch = 0, cmp_count = 0, cyc = 0;
	always #12.5 clk = ~clk;
	always #100 synth_clk = ~synth_clk;
	// reference is the inverse of the synthesizer so a wrong pick shows
	always #100 ext_clk = ~ext_clk;
	always #50 osc_clk = ~osc_clk;
	always #75 tt_clk = ~tt_clk;
	always @(posedge e_rx_clk) e_smp = e_rx_data;
	always @(posedge w_rx_clk) w_smp = w_rx_data;
	lsp_eut #(.PAT(8'ha5)) east_eut (.run, .lt, .txc(tx_clk[0]), .rxd(e_rx_data), .rxc(e_rx_clk));
	lsp_eut #(.PAT(8'h3c)) west_eut (.run, .lt, .txc(tx_clk[1]), .rxd(w_rx_data), .rxc(w_rx_clk));
	lsp_path_core #(.LED_HOLD(8)) DUT (.clk, .nrst, .if_installed, .if_types, .if_sel,
		.if_sel_stb, .if_active, .if_busy, .cfg_wdata, .cfg_wr, .cfg_cur, .path_sel,
		.path_stb, .path_cur, .e_rx_data, .e_rx_clk, .w_rx_data, .w_rx_clk, .synth_clk,
		.osc_clk, .ext_clk, .tt_clk, .tx_data, .tx_clk, .synth_freq,
		.synth_en, .gen_in_data, .gen_in_valid, .gen_out_data(gen_in_data),
		.gen_out_valid(gen_in_valid), .gen_out_ready, .act_led);
	// ****************************************
	// helpers
	// ****************************************
	task automatic cmp(string nm, logic [39:0] exp, logic [39:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmp
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick
	task automatic conclude;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	task automatic pick(logic [2:0] s);
		if_sel = s;
		if_sel_stb = 1'b1;
		tick(1);
		if_sel_stb = 1'b0;
		cmp("if_busy", 1'b1, if_busy);
		tick(4);
		cmp("if_busy", 1'b0, if_busy);
	endtask : pick
	task automatic go_path(logic [1:0] p);
		path_sel = p;
		path_stb = 1'b1;
		tick(1);
		path_stb = 1'b0;
		tick(1);
		cmp("path_cur", p, path_cur);
	endtask : go_path
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_iface;
		cmp("if_active", 5'h00, if_active);
		pick(3'h0);
		cmp("if_active", 5'h01, if_active);
		cmp("rate", lsp_pkg::RATE_DS3, cfg_cur.rate);
		cfg_wdata.rate = 28'h00003e8;
		cfg_wdata.tsrc = lsp_pkg::LSP_TS_INT;
		cfg_wdata.ofs = 16'h0018;
		cfg_wr = 1'b1;
		tick(1);
		cfg_wr = 1'b0;
		tick(2);
		cmp("synth_freq", 28'h0000400, synth_freq);
		cmp("synth_en", 1'b1, synth_en);
		pick(3'h1);
		cmp("if_active", 5'h02, if_active);
		cmp("rate", lsp_pkg::RATE_HSSI, cfg_cur.rate);
		pick(3'h0);
		cmp("rate", 28'h00003e8, cfg_cur.rate);
	endtask : t_iface
	task automatic t_feed(logic [1:0] p);
		int k;
		go_path(p);
		k = 0;
		while (gen_in_valid[0] !== 1'b1 && k < 100) begin
			tick(1);
			k++;
		end
		cmp("gen_v", 1'b1, gen_in_valid[0]);
		cmp("gen_e", p == 2'h0 ? w_smp : e_smp, gen_in_data[0]);
		cmp("gen_w", p == 2'h0 ? e_smp : w_smp, gen_in_data[1]);
		cmp("led_rx", 1'b1, act_led[0]);
		cmp("gen_rdy", 2'h3, gen_out_ready);
	endtask : t_feed
	task automatic t_direct(logic [1:0] p);
		go_path(p);
		repeat (4) begin
			@(posedge w_rx_clk);
			tick(3);
			if (p == 2'h1) begin
				cmp("tx_e", w_rx_data, tx_data[0]);
				cmp("tx_w", e_rx_data, tx_data[1]);
				cmp("led", 4'h0, act_led);
			end else begin
				cmp("tx_e", e_rx_data, tx_data[0]);
				cmp("tx_w", w_rx_data, tx_data[1]);
			end
		end
	endtask : t_direct
	// external timing on the active DS3 slot; equipment loop-times off our tx
	task automatic t_clock;
		go_path(2'h0);
		lt = 1'b1;
		cfg_wdata = '0;
		cfg_wdata.rate = lsp_pkg::RATE_DS3;
		cfg_wdata.tsrc = lsp_pkg::LSP_TS_EXT;
		cfg_wdata.gapped = 1'b1;
		cfg_wdata.async_m = 1'b1;
		cfg_wr = 1'b1;
		tick(1);
		cfg_wr = 1'b0;
		cmp("gapped", 1'b0, cfg_cur.gapped);
		cmp("async", 1'b0, cfg_cur.async_m);
		@(posedge ext_clk);
		tick(4);
		cmp("tx_clk", 2'h3, tx_clk);
		tick(4);
		cmp("tx_clk", 2'h0, tx_clk);
	endtask : t_clock
	// bounded run so a stuck handshake cannot hang the regression
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		tick(10);
		nrst = 1'b1;
		tick(1);
		run = 1'b1;
		t_iface();
		t_feed(2'h0);
		t_feed(2'h3);
		t_direct(2'h1);
		t_direct(2'h2);
		t_clock();
		conclude();
	end
endmodule : link_sim_path_and_timing_select_tb
